// ---- shared/sse_regs.svh ----
`ifndef SSE_REGS_SVH
`define SSE_REGS_SVH
// Register offsets on the plain register port.
`define SSE_REG_ACC   8'h00
`define SSE_REG_STAT  8'h01
`define SSE_REG_TPTR  8'h02
`define SSE_REG_THIGH 8'h03
// Status register bit positions.
`define SSE_BIT_CARRY 0
`define SSE_BIT_AUXC  1
`define SSE_BIT_ZERO  2
`define SSE_BIT_OVFL  3
`define SSE_BIT_PWRDN 4
`define SSE_BIT_WDTO  5
// Reset values.
`define SSE_RST_BYTE  8'h00
`define SSE_RST_STAT  6'h00
`define SSE_RST_THIGH 6'h00
// Widths and sizes.
`define SSE_DW       8
`define SSE_NIB      4
`define SSE_BIT_W    3
`define SSE_STAT_W   6
`define SSE_ROM_W    14
`define SSE_ROM_AW   11
`define SSE_DM_AW    7
`define SSE_DM_DEPTH 96
`endif

// ---- shared/sse_pkg.sv ----
`default_nettype none
package sse_pkg;
	// Operations executed by this block.
	typedef enum logic [3:0] {
		OP_SUB_ACC   = 4'h0,
		OP_SUB_MEM   = 4'h1,
		OP_SUB_IMM   = 4'h2,
		OP_SWAP_MEM  = 4'h3,
		OP_SWAP_ACC  = 4'h4,
		OP_ZERO_TEST = 4'h5,
		OP_COPY_TEST = 4'h6,
		OP_BIT_TEST  = 4'h7,
		OP_TBL_CUR   = 4'h8,
		OP_TBL_LAST  = 4'h9,
		OP_XOR_ACC   = 4'ha,
		OP_XOR_MEM   = 4'hb,
		OP_XOR_IMM   = 4'hc
	} sse_op_e;
	// Sequencer states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_EXEC  = 5'h02,
		ST_DUMMY = 5'h04,
		ST_TREQ  = 5'h08,
		ST_TCAP  = 5'h10
	} sse_state_e;
endpackage : sse_pkg
`default_nettype wire

// ---- rtl/sse_alu.sv ----
`include "sse_regs.svh"
`default_nettype none
module sse_alu #(
	parameter int W = `SSE_DW
) (
	// Operands.
	input  wire logic [W-1:0] opA,
	input  wire logic [W-1:0] opB,
	input  wire logic         doXor,
	// Result and flags.
	output logic      [W-1:0] result,
	output logic              carryOut,
	output logic              auxOut,
	output logic              ovflOut,
	output logic              zeroOut
);
	logic [W:0]        sum;
	logic [`SSE_NIB:0] nib;

	// Subtraction as A plus complement of B plus one.
	assign sum = {1'b0, opA} + {1'b0, ~opB} + {{W{1'b0}}, 1'b1};
	assign nib = {1'b0, opA[`SSE_NIB-1:0]} + {1'b0, ~opB[`SSE_NIB-1:0]}
		+ {{`SSE_NIB{1'b0}}, 1'b1};

	// Result select and flag outputs; carry set means no borrow.
	assign result   = doXor ? (opA ^ opB) : sum[W-1:0];
	assign carryOut = sum[W];
	assign auxOut   = nib[`SSE_NIB];
	assign ovflOut  = (opA[W-1] ^ opB[W-1]) & (opA[W-1] ^ sum[W-1]);
	assign zeroOut  = (result == '0);
endmodule : sse_alu
`default_nettype wire

// ---- rtl/sse_data_ram.sv ----
`include "sse_regs.svh"
`default_nettype none
module sse_data_ram #(
	parameter int DEPTH = `SSE_DM_DEPTH,
	parameter int AW    = `SSE_DM_AW,
	parameter int DW    = `SSE_DW
) (
	// Clock and reset.
	input  wire logic          clk_sys,
	input  wire logic          reset,
	// Write port.
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// Read port, data registered.
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	// Writes beyond the populated depth are dropped.
	always_ff @(posedge clk_sys) begin
		if (we && (waddr < AW'(DEPTH))) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read; unpopulated addresses read as zero.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata <= '0;
		end else if (re) begin
			rdata <= (raddr < AW'(DEPTH)) ? mem[raddr] : '0;
		end
	end
endmodule : sse_data_ram
`default_nettype wire

// ---- rtl/sse_exec.sv ----
// The implementer's own choices: the strobed register port and the address map.
`include "sse_regs.svh"
`default_nettype none
// Summary of operation
// - Subtract memory from accumulator, four flags.
// - Same subtraction, result written to memory.
// - Subtract immediate from accumulator, four flags.
// - Swap memory byte nibbles in place.
// - Swapped memory byte into accumulator only.
// - Skip next when memory byte zero.
// - Copy byte to accumulator, skip if zero.
// - Skip next when selected bit clear.
// - Skip adds dummy cycle, discards prefetch.
// - Table read current page to memory/high.
// - Table read last page likewise.
// - XOR memory into accumulator, zero only.
// - XOR result into memory, zero only.
// - XOR immediate into accumulator, zero only.
module sse_exec #(
	parameter int DM_DEPTH = `SSE_DM_DEPTH,
	parameter int DM_AW    = `SSE_DM_AW,
	parameter int ROM_AW   = `SSE_ROM_AW
) (
	// Clock and reset.
	input  wire logic                      clk_sys,
	input  wire logic                      reset,
	// Register port.
	input  wire logic [`SSE_DW-1:0]        regAddr,
	input  wire logic [`SSE_DW-1:0]        regWdata,
	input  wire logic                      regWrite,
	input  wire logic                      regRead,
	output logic      [`SSE_DW-1:0]        regRdata,
	// Instruction request.
	input  wire logic                      instValid,
	input  wire sse_pkg::sse_op_e          instOp,
	input  wire logic [DM_AW-1:0]          instAddr,
	input  wire logic [`SSE_BIT_W-1:0]     instBit,
	input  wire logic [`SSE_DW-1:0]        instImm,
	input  wire logic [ROM_AW-`SSE_DW-1:0] instPage,
	output logic                           instReady,
	output logic                           instDone,
	output logic                           discardFetch,
	// Program ROM port.
	output logic                           romRead,
	output logic      [ROM_AW-1:0]         romAddr,
	input  wire logic [`SSE_ROM_W-1:0]     romData
);
	localparam int DW = `SSE_DW;
	localparam int HW = `SSE_ROM_W - `SSE_DW;
	localparam int PW = ROM_AW - `SSE_DW;

	sse_pkg::sse_state_e     stateReg;
	sse_pkg::sse_state_e     stateNext;
	sse_pkg::sse_op_e        opReg;
	logic [DM_AW-1:0]        addrReg;
	logic [`SSE_BIT_W-1:0]   bitReg;
	logic [DW-1:0]           immReg;
	logic [DW-1:0]           accReg;
	logic [DW-1:0]           accNext;
	logic [`SSE_STAT_W-1:0]  statReg;
	logic [`SSE_STAT_W-1:0]  statNext;
	logic [DW-1:0]           tptrReg;
	logic [HW-1:0]           thighReg;
	logic                    inIdle;
	logic                    inExec;
	logic                    inDummy;
	logic                    inTreq;
	logic                    inTcap;
	logic                    accept;
	logic                    isTable;
	logic                    ramRe;
	logic                    ramWe;
	logic [DW-1:0]           ramWdata;
	logic [DW-1:0]           ramQ;
	logic [DW-1:0]           swapQ;
	logic [DW-1:0]           aluB;
	logic [DW-1:0]           aluRes;
	logic                    aluC;
	logic                    aluAc;
	logic                    aluOv;
	logic                    aluZ;
	logic                    doXor;
	logic                    doSub;
	logic                    skipCond;

	// State decode and request handshake.
	assign inIdle    = (stateReg == sse_pkg::ST_IDLE);
	assign inExec    = (stateReg == sse_pkg::ST_EXEC);
	assign inDummy   = (stateReg == sse_pkg::ST_DUMMY);
	assign inTreq    = (stateReg == sse_pkg::ST_TREQ);
	assign inTcap    = (stateReg == sse_pkg::ST_TCAP);
	assign instReady = inIdle;
	assign accept    = inIdle && instValid;
	assign isTable   = (instOp == sse_pkg::OP_TBL_CUR)
		|| (instOp == sse_pkg::OP_TBL_LAST);
	assign ramRe     = accept && !isTable;
	assign romRead   = inTreq;
	assign instDone  = (inExec && !skipCond) || inDummy || inTcap;
	assign discardFetch = inDummy;

	// Operand classes of the latched operation.
	assign doXor = (opReg == sse_pkg::OP_XOR_ACC)
		|| (opReg == sse_pkg::OP_XOR_MEM)
		|| (opReg == sse_pkg::OP_XOR_IMM);
	assign doSub = (opReg == sse_pkg::OP_SUB_ACC)
		|| (opReg == sse_pkg::OP_SUB_MEM)
		|| (opReg == sse_pkg::OP_SUB_IMM);
	assign aluB  = ((opReg == sse_pkg::OP_SUB_IMM)
		|| (opReg == sse_pkg::OP_XOR_IMM)) ? immReg : ramQ;
	assign swapQ = {ramQ[`SSE_NIB-1:0], ramQ[DW-1:`SSE_NIB]};

	// Shared subtract and exclusive-OR unit.
	sse_alu #(
		.W (DW)
	) u_alu (
		.opA      (accReg),
		.opB      (aluB),
		.doXor    (doXor),
		.result   (aluRes),
		.carryOut (aluC),
		.auxOut   (aluAc),
		.ovflOut  (aluOv),
		.zeroOut  (aluZ)
	);

	// Data memory with registered read.
	sse_data_ram #(
		.DEPTH (DM_DEPTH),
		.AW    (DM_AW),
		.DW    (DW)
	) u_ram (
		.clk_sys (clk_sys),
		.reset   (reset),
		.we      (ramWe),
		.waddr   (addrReg),
		.wdata   (ramWdata),
		.re      (ramRe),
		.raddr   (instAddr),
		.rdata   (ramQ)
	);

	// Skip decision, evaluated while the operand byte is present.
	always_comb begin
		skipCond = 1'b0;
		if (inExec) begin
			unique case (opReg)
				sse_pkg::OP_ZERO_TEST: skipCond = (ramQ == '0);
				sse_pkg::OP_COPY_TEST: skipCond = (ramQ == '0);
				sse_pkg::OP_BIT_TEST:  skipCond = !ramQ[bitReg];
				default:               skipCond = 1'b0;
			endcase
		end
	end

	// Sequencer: skips add a dummy cycle, table reads wait on the ROM.
	always_comb begin
		stateNext = stateReg;
		unique case (stateReg)
			sse_pkg::ST_IDLE: begin
				if (accept) begin
					stateNext = isTable ? sse_pkg::ST_TREQ
						: sse_pkg::ST_EXEC;
				end
			end
			sse_pkg::ST_EXEC: begin
				stateNext = skipCond ? sse_pkg::ST_DUMMY
					: sse_pkg::ST_IDLE;
			end
			sse_pkg::ST_DUMMY: stateNext = sse_pkg::ST_IDLE;
			sse_pkg::ST_TREQ:  stateNext = sse_pkg::ST_TCAP;
			sse_pkg::ST_TCAP:  stateNext = sse_pkg::ST_IDLE;
			default:           stateNext = sse_pkg::ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stateReg <= sse_pkg::ST_IDLE;
		end else begin
			stateReg <= stateNext;
		end
	end

	// Operands latched when a request is taken.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			opReg   <= sse_pkg::OP_SUB_ACC;
			addrReg <= '0;
			bitReg  <= '0;
			immReg  <= `SSE_RST_BYTE;
		end else if (accept) begin
			opReg   <= instOp;
			addrReg <= instAddr;
			bitReg  <= instBit;
			immReg  <= instImm;
		end
	end

	// ROM address: table pointer within the chosen page.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			romAddr <= '0;
		end else if (accept && isTable) begin
			romAddr <= {(instOp == sse_pkg::OP_TBL_LAST) ? {PW{1'b1}}
				: instPage, tptrReg};
		end
	end

	// Data memory write-back.
	always_comb begin
		ramWe    = 1'b0;
		ramWdata = ramQ;
		if (inExec) begin
			unique case (opReg)
				sse_pkg::OP_SUB_MEM: begin
					ramWe    = 1'b1;
					ramWdata = aluRes;
				end
				sse_pkg::OP_XOR_MEM: begin
					ramWe    = 1'b1;
					ramWdata = aluRes;
				end
				sse_pkg::OP_SWAP_MEM: begin
					ramWe    = 1'b1;
					ramWdata = swapQ;
				end
				default: ramWe = 1'b0;
			endcase
		end else if (inTcap) begin
			ramWe    = 1'b1;
			ramWdata = romData[DW-1:0];
		end
	end

	// Accumulator next value; an executing operation wins over software.
	always_comb begin
		accNext = accReg;
		if (regWrite && (regAddr == `SSE_REG_ACC)) begin
			accNext = regWdata;
		end
		if (inExec) begin
			unique case (opReg)
				sse_pkg::OP_SUB_ACC:   accNext = aluRes;
				sse_pkg::OP_SUB_IMM:   accNext = aluRes;
				sse_pkg::OP_XOR_ACC:   accNext = aluRes;
				sse_pkg::OP_XOR_IMM:   accNext = aluRes;
				sse_pkg::OP_SWAP_ACC:  accNext = swapQ;
				sse_pkg::OP_COPY_TEST: accNext = ramQ;
				default:               accNext = accNext;
			endcase
		end
	end

	// Status flags; operations never touch power-down and timeout, only a status write does.
	always_comb begin
		statNext = statReg;
		if (regWrite && (regAddr == `SSE_REG_STAT)) begin
			statNext = regWdata[`SSE_STAT_W-1:0];
		end
		if (inExec && doSub) begin
			statNext[`SSE_BIT_CARRY] = aluC;
			statNext[`SSE_BIT_AUXC]  = aluAc;
			statNext[`SSE_BIT_ZERO]  = aluZ;
			statNext[`SSE_BIT_OVFL]  = aluOv;
		end else if (inExec && doXor) begin
			statNext[`SSE_BIT_ZERO]  = aluZ;
		end
	end

	// Accumulator and status registers.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			accReg  <= `SSE_RST_BYTE;
			statReg <= `SSE_RST_STAT;
		end else begin
			accReg  <= accNext;
			statReg <= statNext;
		end
	end

	// Table pointer, written by software only.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tptrReg <= `SSE_RST_BYTE;
		end else if (regWrite && (regAddr == `SSE_REG_TPTR)) begin
			tptrReg <= regWdata;
		end
	end

	// Table-high register takes the upper part of the ROM word.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			thighReg <= `SSE_RST_THIGH;
		end else if (inTcap) begin
			thighReg <= romData[`SSE_ROM_W-1:DW];
		end
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clk_sys) begin
		if (reset || !regRead) begin
			regRdata <= '0;
		end else begin
			unique case (regAddr)
				`SSE_REG_ACC:   regRdata <= accReg;
				`SSE_REG_STAT:  regRdata <= DW'(statReg);
				`SSE_REG_TPTR:  regRdata <= tptrReg;
				`SSE_REG_THIGH: regRdata <= DW'(thighReg);
				default:        regRdata <= '0;
			endcase
		end
	end

	// Checks on the executing operation.
	sequence s_skipTaken;
		inExec && skipCond;
	endsequence

	sequence s_dummyEnd;
		inDummy && discardFetch && instDone ##1 inIdle;
	endsequence

	sequence s_tableWalk;
		romRead && !instDone ##1 inTcap && ramWe && instDone;
	endsequence

	a_sub_acc_value: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_SUB_ACC
		|=> accReg == DW'($past(accReg) - $past(ramQ)))
		else $error("Subtract to accumulator gave a wrong value.");

	a_sub_carry_flag: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && doSub && !regWrite
		|=> statReg[`SSE_BIT_CARRY] == ($past(accReg) >= $past(aluB))
		&& $stable(statReg[`SSE_BIT_WDTO:`SSE_BIT_PWRDN]))
		else $error("Subtract carry or held flags wrong.");

	a_sub_mem_write: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_SUB_MEM && !regWrite
		|-> ramWe && ramWdata == DW'(accReg - ramQ) ##1 $stable(accReg))
		else $error("Subtract to memory write wrong.");

	a_sub_imm_value: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_SUB_IMM
		|=> accReg == DW'($past(accReg) - $past(immReg)))
		else $error("Subtract immediate gave a wrong value.");

	a_swap_mem_write: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_SWAP_MEM && !regWrite
		|-> ramWe && ramWdata[`SSE_NIB-1:0] == ramQ[DW-1:`SSE_NIB]
		&& ramWdata[DW-1:`SSE_NIB] == ramQ[`SSE_NIB-1:0]
		##1 $stable(statReg))
		else $error("Nibble swap in memory wrong.");

	a_swap_acc_value: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_SWAP_ACC && !regWrite
		|-> !ramWe ##1 accReg[`SSE_NIB-1:0] == $past(ramQ[DW-1:`SSE_NIB])
		&& accReg[DW-1:`SSE_NIB] == $past(ramQ[`SSE_NIB-1:0])
		&& $stable(statReg))
		else $error("Nibble swap to accumulator wrong.");

	a_zero_test: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_ZERO_TEST && !regWrite
		|-> skipCond == (ramQ == '0) && !ramWe ##1 $stable(statReg))
		else $error("Zero test decision wrong.");

	a_copy_test: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_COPY_TEST && !regWrite
		|-> skipCond == (ramQ == '0)
		##1 accReg == $past(ramQ) && $stable(statReg))
		else $error("Copy and test wrong.");

	a_bit_test: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_BIT_TEST
		|-> skipCond == ((ramQ & (DW'(1) << bitReg)) == '0) && !ramWe)
		else $error("Bit test decision wrong.");

	a_skip_dummy: assert property (@(posedge clk_sys) disable iff (reset)
		s_skipTaken |-> !instDone ##1 s_dummyEnd)
		else $error("Skip did not insert one dummy cycle.");

	a_no_skip_one: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && !skipCond |-> instDone && !discardFetch ##1 inIdle)
		else $error("Plain instruction took more than one cycle.");

	a_table_walk: assert property (@(posedge clk_sys) disable iff (reset)
		accept && isTable |=> s_tableWalk
		##1 thighReg == $past(romData[`SSE_ROM_W-1:DW], 1))
		else $error("Table read sequence wrong.");

	a_table_page: assert property (@(posedge clk_sys) disable iff (reset)
		accept && instOp == sse_pkg::OP_TBL_LAST
		|=> romAddr == {{PW{1'b1}}, $past(tptrReg)})
		else $error("Last page table address wrong.");

	a_xor_zero_only: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && doXor && !regWrite
		|=> statReg[`SSE_BIT_ZERO] == (($past(accReg) ^ $past(aluB)) == '0)
		&& $stable(statReg[`SSE_BIT_OVFL])
		&& $stable(statReg[`SSE_BIT_AUXC:`SSE_BIT_CARRY])
		&& $stable(statReg[`SSE_BIT_WDTO:`SSE_BIT_PWRDN]))
		else $error("Exclusive-OR touched a flag besides zero.");

	a_xor_mem_write: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_XOR_MEM
		|-> ramWe && ramWdata == (accReg ^ ramQ))
		else $error("Exclusive-OR to memory write wrong.");

	a_xor_imm_value: assert property (@(posedge clk_sys) disable iff (reset)
		inExec && opReg == sse_pkg::OP_XOR_IMM
		|=> accReg == ($past(accReg) ^ $past(immReg)))
		else $error("Exclusive-OR immediate wrong.");
endmodule : sse_exec
`default_nettype wire

// ---- tb/sse_rom_model.sv ----
`default_nettype none
module sse_rom_model (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Read request from the block.
	input  wire logic        romRead,
	input  wire logic [10:0] romAddr,
	// Word returned one cycle later.
	output logic      [13:0] romData
);
	timeunit 1ns;
	timeprecision 100ps;

	// A read is answered in the next cycle; outside that the word flips
	// every cycle, so a late or early sample never sees a stale word.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			romData <= 14'h0000;
		end else if (romRead) begin
			romData <= {romAddr[10:5], romAddr[7:0] ^ 8'h5a};
		end else begin
			romData <= ~romData;
		end
	end
endmodule : sse_rom_model
`default_nettype wire

// ---- tb/tb_mcu_subtract_swap_skip_xor_exec.sv ----
`include "sse_regs.svh"
`default_nettype none
module tb_mcu_subtract_swap_skip_xor_exec;
	timeunit 1ns;
	timeprecision 100ps;

	logic             clk_sys = 1'b0;
	logic             reset;
	logic [7:0]       regAddr;
	logic [7:0]       regWdata;
	logic             regWrite;
	logic             regRead;
	logic [7:0]       regRdata;
	logic             instValid;
	sse_pkg::sse_op_e instOp;
	logic [6:0]       instAddr;
	logic [2:0]       instBit;
	logic [7:0]       instImm;
	logic [2:0]       instPage;
	logic             instReady;
	logic             instDone;
	logic             discardFetch;
	logic             romRead;
	logic [10:0]      romAddr;
	logic [13:0]      romData;
	int               failures = 0;
	int               comparisons = 0;
	int               cycles = 0;

	// The block under test and its program store.
	sse_exec u_dut (
		.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .instValid(instValid), .instOp(instOp),
		.instAddr(instAddr), .instBit(instBit), .instImm(instImm),
		.instPage(instPage), .instReady(instReady), .instDone(instDone),
		.discardFetch(discardFetch), .romRead(romRead),
		.romAddr(romAddr), .romData(romData)
	);
	sse_rom_model u_rom (
		.clk_sys(clk_sys), .reset(reset), .romRead(romRead),
		.romAddr(romAddr), .romData(romData)
	);

	// Clock at 40 MHz.
	always #12.5 clk_sys = ~clk_sys;

	// Cuts a hung run short.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic conclude();
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [7:0] exp,
			input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Register write: one strobe cycle, then one idle cycle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	// Register read: data is looked at in the cycle after the strobe.
	task automatic rd(input string name, input logic [7:0] a,
			input logic [7:0] exp);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		chk(name, exp, regRdata);
		@(posedge clk_sys);
	endtask : rd

	// Issues one instruction and counts cycles up to its completion.
	task automatic run(input sse_pkg::sse_op_e op, input logic [6:0] adr,
			input logic [2:0] bi, input logic [7:0] imm, input logic [2:0] pg,
			input int cyc, input logic disc);
		int n;
		n = 1;
		instValid <= 1'b1;
		instOp    <= op;
		instAddr  <= adr;
		instBit   <= bi;
		instImm   <= imm;
		instPage  <= pg;
		@(posedge clk_sys);
		instValid <= 1'b0;
		#1;
		chk("instReady", 8'h00, {7'h0, instReady});
		while (instDone !== 1'b1 && n < 4) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("cycles", 8'(cyc), 8'(n));
		chk("discardFetch", {7'h0, disc}, {7'h0, discardFetch});
		@(posedge clk_sys);
	endtask : run

	// Reads a memory byte back through the copy-and-test operation.
	task automatic peek(input logic [6:0] adr, input logic [7:0] v);
		run(sse_pkg::OP_COPY_TEST, adr, 3'h0, 8'h00, 3'h0,
			(v == 8'h00) ? 2 : 1, v == 8'h00);
		rd("memory", `SSE_REG_ACC, v);
	endtask : peek

	// Seeds a memory byte through a table read of a known ROM word.
	task automatic poke(input logic [6:0] adr, input logic [7:0] v,
			input logic [2:0] pg, input logic last);
		logic [7:0] tp;
		logic [2:0] ep;
		tp = v ^ 8'h5a;
		ep = last ? 3'h7 : pg;
		wr(`SSE_REG_TPTR, tp);
		run(last ? sse_pkg::OP_TBL_LAST : sse_pkg::OP_TBL_CUR, adr, 3'h0,
			8'h00, pg, 2, 1'b0);
		rd("tableHigh", `SSE_REG_THIGH, {2'b00, ep, tp[7:5]});
	endtask : poke

	// Runs one data operation and checks accumulator, status and memory.
	task automatic arith(input sse_pkg::sse_op_e op, input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] st);
		logic [8:0] s;
		logic [4:0] hs;
		logic [7:0] mv;
		logic [7:0] ea;
		logic [7:0] em;
		logic [7:0] es;
		mv = (op inside {sse_pkg::OP_SUB_IMM, sse_pkg::OP_XOR_IMM}) ? ~b : b;
		poke(7'h05, mv, 3'h2, 1'b0);
		wr(`SSE_REG_ACC, a);
		wr(`SSE_REG_STAT, st);
		run(op, 7'h05, 3'h0, b, 3'h0, 1, 1'b0);
		s  = {1'b0, a} + {1'b0, ~b} + 9'h001;
		hs = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		ea = a;
		em = mv;
		es = st;
		case (op)
			sse_pkg::OP_SUB_ACC, sse_pkg::OP_SUB_IMM: ea = s[7:0];
			sse_pkg::OP_SUB_MEM: em = s[7:0];
			sse_pkg::OP_SWAP_MEM: em = {b[3:0], b[7:4]};
			sse_pkg::OP_SWAP_ACC: ea = {b[3:0], b[7:4]};
			sse_pkg::OP_XOR_MEM: em = a ^ b;
			default: ea = a ^ b;
		endcase
		if (op inside {sse_pkg::OP_SUB_ACC, sse_pkg::OP_SUB_MEM,
				sse_pkg::OP_SUB_IMM}) begin
			es[3:0] = {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
				hs[4], s[8]};
		end else if (op inside {sse_pkg::OP_XOR_ACC, sse_pkg::OP_XOR_MEM,
				sse_pkg::OP_XOR_IMM}) begin
			es[2] = (a ^ b) == 8'h00;
		end
		rd("accumulator", `SSE_REG_ACC, ea);
		rd("status", `SSE_REG_STAT, es);
		peek(7'h05, em);
	endtask : arith

	// Main sequence.
	initial begin
		reset     <= 1'b1;
		regAddr   <= 8'h00;
		regWdata  <= 8'h00;
		regWrite  <= 1'b0;
		regRead   <= 1'b0;
		instValid <= 1'b0;
		instOp    <= sse_pkg::OP_SUB_ACC;
		instAddr  <= 7'h00;
		instBit   <= 3'h0;
		instImm   <= 8'h00;
		instPage  <= 3'h0;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		// Reset values, read-only and unmapped places.
		rd("accumulator", `SSE_REG_ACC, 8'h00);
		rd("status", `SSE_REG_STAT, 8'h00);
		rd("tablePointer", `SSE_REG_TPTR, 8'h00);
		wr(`SSE_REG_THIGH, 8'hff);
		rd("tableHigh", `SSE_REG_THIGH, 8'h00);
		rd("unmapped", 8'h07, 8'h00);
		// Arithmetic, swap and exclusive-OR cases with edge values.
		arith(sse_pkg::OP_SUB_ACC, 8'h50, 8'h70, 8'h30);
		arith(sse_pkg::OP_SUB_ACC, 8'h80, 8'h01, 8'h00);
		arith(sse_pkg::OP_SUB_MEM, 8'h3c, 8'h3c, 8'h0f);
		arith(sse_pkg::OP_SUB_IMM, 8'h7f, 8'hff, 8'h20);
		arith(sse_pkg::OP_SWAP_MEM, 8'h11, 8'h9c, 8'h2a);
		arith(sse_pkg::OP_SWAP_ACC, 8'h22, 8'he1, 8'h15);
		arith(sse_pkg::OP_XOR_ACC, 8'h5a, 8'h5a, 8'h3b);
		arith(sse_pkg::OP_XOR_MEM, 8'hf0, 8'h0f, 8'h04);
		arith(sse_pkg::OP_XOR_IMM, 8'h81, 8'h18, 8'h00);
		// Skip tests on the byte and on every bit position.
		poke(7'h10, 8'h00, 3'h1, 1'b1);
		poke(7'h11, 8'ha5, 3'h4, 1'b0);
		wr(`SSE_REG_STAT, 8'h3f);
		run(sse_pkg::OP_ZERO_TEST, 7'h10, 3'h0, 8'h00, 3'h0, 2, 1'b1);
		run(sse_pkg::OP_ZERO_TEST, 7'h11, 3'h0, 8'h00, 3'h0, 1, 1'b0);
		for (int i = 0; i < 8; i++) begin
			run(sse_pkg::OP_BIT_TEST, 7'h11, 3'(i), 8'h00, 3'h0,
				(8'ha5 >> i) & 1 ? 1 : 2, !((8'ha5 >> i) & 1));
		end
		rd("status", `SSE_REG_STAT, 8'h3f);
		peek(7'h10, 8'h00);
		rd("status", `SSE_REG_STAT, 8'h3f);
		conclude();
	end
endmodule : tb_mcu_subtract_swap_skip_xor_exec
`default_nettype wire
